// [logic/spi_port_pkg.sv]
// shared constants and types for the serial control port of the transceiver
// assumes one core clock domain; the serial link is oversampled by that clock
package spi_port_pkg;
  // word and address geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int MEM_DEPTH = 64;
  localparam int HDR_BITS = 8;
  localparam int WORD_BITS = 16;
  localparam int FRAME_MIN_EDGES = 24;
  // header: read/write flag sits seven places above the shift input when the header ends
  localparam int HDR_RW_IDX = 6;
  // serial register map
  localparam logic [5:0] REG_SOFT_RESET = 6'h00;
  localparam logic [5:0] REG_RX_RAM = 6'h01;
  localparam logic [5:0] REG_TX_RAM = 6'h02;
  localparam logic [5:0] REG_WRAP_TARGET = 6'h03;
  localparam logic [5:0] REG_LAST = 6'h3F;
  localparam logic [5:0] REG_FLOAT_CTRL = 6'h07;
  localparam logic [5:0] REG_DRIVE_CTRL = 6'h0C;
  localparam int FLOAT_BIT = 0;
  localparam int DRIVE_LSB = 0;
  // values after reset
  localparam logic FLOAT_RST = 1'b1;
  localparam logic [1:0] DRIVE_RST = 2'h0;
  // symbol packing
  localparam int SYM_W = 4;
  localparam int SYMS_PER_WORD = 4;
  // apb map (byte addresses)
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_SYMBOL = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_TXPEEK = 8'h0C;
  localparam int CTRL_STREAM_BIT = 0;
  localparam int CTRL_RXCLR_BIT = 1;

  typedef enum logic {PH_HEADER, PH_DATA} phase_t;
  typedef enum logic [1:0] {SRC_REGS, SRC_RX_RAM, SRC_STREAM} src_t;

  // one request to a word store
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic re;
    logic [ADDR_W-1:0] raddr;
  } mem_req_t;
endpackage : spi_port_pkg

// [logic/word_store.sv]
// small word memory with registered read data
// assumes requests come from logic on core_clk
module word_store
  import spi_port_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire mem_req_t req, // write and read request
  output logic [DATA_W-1:0] rdata_q // read data, one cycle after re
);
  // refuse depths the address cannot reach
  if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_depth_check
    $error("word_store depth out of range");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  // write port; reset clears every word so read-ahead never yields unknowns
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (req.we) begin
      mem[req.waddr] <= req.wdata;
    end
  end

  // registered read port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (req.re) begin
      rdata_q <= mem[req.raddr];
    end
  end
endmodule : word_store

// [logic/spi_slave_port.sv]
// serial slave control port: header, 16-bit words, recursive access, miso control
// assumes the serial clock is far slower than core_clk and is sampled by it
module spi_slave_port
  import spi_port_pkg::*;
(
  input wire logic core_clk, // core clock, 250 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic serial_clock_in, // serial clock from host
  input wire logic chip_en_n, // chip enable, active low
  input wire logic mosi_in, // host to device data
  output logic miso_out, // device to host data
  output logic miso_oe, // miso output enable, high drives
  output logic [1:0] miso_drive, // miso strength select
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error
);
  logic sclk_m, sclk_s, sclk_d, ce_m, ce_s, mosi_m, mosi_s;
  logic rise, fall, hdr_done, word_done, rd_req, wr_commit, soft_reset;
  logic load_q, rw_q, float_q, stream_q, miso_q, miso_oe_q;
  logic [1:0] drive_q, sym_cnt_q;
  phase_t phase_q;
  src_t src_q, src_d;
  logic [3:0] cnt_q;
  logic [5:0] ptr_q, ram_ptr_q, rx_wptr_q, peek_q, hdr_addr, rd_addr;
  logic [15:0] sh_q, tx_sh_q, word_in, stream_buf_q, pack_q, sym_word;
  logic [15:0] regs_rdata, rx_rdata, tx_rdata;
  logic [31:0] prdata_q;
  logic [4:0] edges_q;
  logic apb_wr, sym_push, word_ready;
  mem_req_t regs_req, rx_req, tx_req;

  // packet memory addresses keep the register pointer fixed
  function automatic logic is_ram(input logic [5:0] a);
    is_ram = (a == REG_RX_RAM) || (a == REG_TX_RAM);
  endfunction : is_ram

  // register pointer advance with wrap past the top
  function automatic logic [5:0] next_ptr(input logic [5:0] p);
    if (is_ram(p)) begin
      next_ptr = p;
    end else if (p == REG_LAST) begin
      next_ptr = REG_WRAP_TARGET;
    end else begin
      next_ptr = p + 6'h01;
    end
  endfunction : next_ptr

  // apb address decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == APB_CTRL) || (a == APB_SYMBOL) || (a == APB_STATUS) ||
      (a == APB_TXPEEK);
  endfunction : is_mapped

  // two-stage synchronisers for pins, then an edge history stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      ce_m <= 1'b1;
      ce_s <= 1'b1;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
    end else begin
      sclk_m <= serial_clock_in;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      ce_m <= chip_en_n;
      ce_s <= ce_m;
      mosi_m <= mosi_in;
      mosi_s <= mosi_m;
    end
  end

  // serial clock edges inside a frame; we never drive the clock
  assign rise = sclk_s && !sclk_d && !ce_s;
  assign fall = !sclk_s && sclk_d && !ce_s;
  assign hdr_done = rise && (phase_q == PH_HEADER) && (cnt_q == 4'(HDR_BITS - 1));
  assign word_done = rise && (phase_q == PH_DATA) && (cnt_q == 4'(WORD_BITS - 1));
  assign hdr_addr = {sh_q[4:0], mosi_s};
  assign word_in = {sh_q[14:0], mosi_s};

  // bit counter and header/data phase; deselect restarts the header
  always_ff @(posedge core_clk) begin
    if (rst || ce_s) begin
      phase_q <= PH_HEADER;
      cnt_q <= 4'h0;
    end else if (rise) begin
      if (hdr_done || word_done) begin
        phase_q <= PH_DATA;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // incoming shift register, direction and pointer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sh_q <= 16'h0000;
      rw_q <= 1'b0;
      ptr_q <= 6'h00;
    end else if (rise) begin
      sh_q <= word_in;
      if (hdr_done) begin
        rw_q <= sh_q[HDR_RW_IDX];
        ptr_q <= hdr_addr;
      end else if (word_done) begin
        ptr_q <= next_ptr(ptr_q);
      end
    end
  end

  // packet memory word pointer restarts at each header
  always_ff @(posedge core_clk) begin
    if (rst || soft_reset || hdr_done) begin
      ram_ptr_q <= 6'h00;
    end else if (word_done && is_ram(ptr_q)) begin
      ram_ptr_q <= ram_ptr_q + 6'h01;
    end
  end

  // read requests at header end and each word boundary of a read
  assign rd_req = (hdr_done && sh_q[HDR_RW_IDX]) || (word_done && rw_q);
  assign rd_addr = hdr_done ? hdr_addr : next_ptr(ptr_q);
  always_comb begin
    src_d = SRC_REGS;
    if (rd_addr == REG_RX_RAM) begin
      src_d = stream_q ? SRC_STREAM : SRC_RX_RAM;
    end
  end

  // writes commit only on a completed word (edge 24 or later)
  assign wr_commit = word_done && !rw_q;
  assign soft_reset = wr_commit && (ptr_q == REG_SOFT_RESET);

  always_comb begin
    regs_req.we = wr_commit && !is_ram(ptr_q) && (ptr_q != REG_SOFT_RESET);
    regs_req.waddr = ptr_q;
    regs_req.wdata = word_in;
    regs_req.re = rd_req;
    regs_req.raddr = rd_addr;
    tx_req.we = wr_commit && (ptr_q == REG_TX_RAM);
    tx_req.waddr = ram_ptr_q;
    tx_req.wdata = word_in;
    tx_req.re = 1'b1;
    tx_req.raddr = peek_q;
    rx_req.we = word_ready && !stream_q;
    rx_req.waddr = rx_wptr_q;
    rx_req.wdata = sym_word;
    rx_req.re = rd_req;
    rx_req.raddr = hdr_done ? 6'h00 : ram_ptr_q + 6'h01;
  end

  word_store #(.DEPTH(MEM_DEPTH)) u_regs (
    .core_clk(core_clk),
    .rst(rst),
    .req(regs_req),
    .rdata_q(regs_rdata)
  );
  word_store #(.DEPTH(MEM_DEPTH)) u_rx_ram (
    .core_clk(core_clk),
    .rst(rst),
    .req(rx_req),
    .rdata_q(rx_rdata)
  );
  word_store #(.DEPTH(MEM_DEPTH)) u_tx_ram (
    .core_clk(core_clk),
    .rst(rst),
    .req(tx_req),
    .rdata_q(tx_rdata)
  );

  // miso float and drive controls, restored by soft reset
  always_ff @(posedge core_clk) begin
    if (rst || soft_reset) begin
      float_q <= FLOAT_RST;
      drive_q <= DRIVE_RST;
    end else if (regs_req.we) begin
      if (ptr_q == REG_FLOAT_CTRL) begin
        float_q <= word_in[FLOAT_BIT];
      end
      if (ptr_q == REG_DRIVE_CTRL) begin
        drive_q <= word_in[DRIVE_LSB +: 2];
      end
    end
  end

  // outgoing word: loaded a cycle after the read, shifted on falling edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_q <= 1'b0;
      src_q <= SRC_REGS;
      tx_sh_q <= 16'h0000;
    end else begin
      load_q <= rd_req;
      if (rd_req) begin
        src_q <= src_d;
      end
      if (load_q) begin
        unique case (src_q)
          SRC_REGS: tx_sh_q <= regs_rdata;
          SRC_RX_RAM: tx_sh_q <= rx_rdata;
          SRC_STREAM: tx_sh_q <= stream_buf_q;
          default: tx_sh_q <= 16'h0000;
        endcase
      end else if (fall && phase_q == PH_DATA) begin
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      end
    end
  end

  // miso pin: data on falling edges of a read, idle per float control
  always_ff @(posedge core_clk) begin
    if (rst || ce_s) begin
      miso_q <= 1'b0;
    end else if (fall && phase_q == PH_DATA && rw_q) begin
      miso_q <= tx_sh_q[15];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= !ce_s || !float_q;
    end
  end
  assign miso_out = miso_q;
  assign miso_oe = miso_oe_q;
  assign miso_drive = drive_q;

  // symbol packing: first symbol in the low nibble, so it leaves last
  assign apb_wr = psel && penable && pwrite;
  assign sym_push = apb_wr && (paddr == APB_SYMBOL);
  assign word_ready = sym_push && (sym_cnt_q == 2'(SYMS_PER_WORD - 1));
  assign sym_word = {pwdata[SYM_W-1:0], pack_q[11:0]};
  always_ff @(posedge core_clk) begin
    if (rst || (apb_wr && paddr == APB_CTRL && pwdata[CTRL_RXCLR_BIT])) begin
      sym_cnt_q <= 2'h0;
      pack_q <= 16'h0000;
      rx_wptr_q <= 6'h00;
    end else if (sym_push) begin
      sym_cnt_q <= sym_cnt_q + 2'h1;
      pack_q[sym_cnt_q*SYM_W +: SYM_W] <= pwdata[SYM_W-1:0];
      if (word_ready && !stream_q) begin
        rx_wptr_q <= rx_wptr_q + 6'h01;
      end
    end
  end

  // stream mode word goes straight to the port buffer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stream_buf_q <= 16'h0000;
    end else if (word_ready && stream_q) begin
      stream_buf_q <= sym_word;
    end
  end

  // apb control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stream_q <= 1'b0;
      peek_q <= 6'h00;
    end else if (apb_wr) begin
      if (paddr == APB_CTRL) begin
        stream_q <= pwdata[CTRL_STREAM_BIT];
      end
      if (paddr == APB_TXPEEK) begin
        peek_q <= pwdata[5:0];
      end
    end
  end

  // apb read data captured in the setup cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        APB_CTRL: prdata_q <= {31'h0000_0000, stream_q};
        APB_SYMBOL: prdata_q <= {24'h00_0000, rx_wptr_q, sym_cnt_q};
        APB_STATUS: prdata_q <= {13'h0000, drive_q, float_q, 2'h0, ram_ptr_q,
          ptr_q, rw_q, !ce_s};
        APB_TXPEEK: prdata_q <= {10'h000, peek_q, tx_rdata};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);

  // rising edges seen in the current frame, saturating
  always_ff @(posedge core_clk) begin
    if (rst || ce_s) begin
      edges_q <= 5'h00;
    end else if (rise && edges_q != 5'h1F) begin
      edges_q <= edges_q + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_float_release: assert property (ce_s && float_q |=> !miso_oe)
    else $error("miso driven while deselected with float set");
  a_idle_drive_low: assert property (ce_s && !float_q |=> miso_oe && !miso_out)
    else $error("miso not driven low while deselected");
  a_no_early_write: assert property (regs_req.we || tx_req.we || soft_reset |->
    edges_q >= 5'(FRAME_MIN_EDGES - 1) && rise)
    else $error("register write before a full word");
  a_pointer_wrap: assert property (word_done && ptr_q == REG_LAST |=>
    ptr_q == REG_WRAP_TARGET)
    else $error("pointer did not wrap to three");
  a_ram_ptr_fixed: assert property (word_done && is_ram(ptr_q) |=>
    $stable(ptr_q) && ram_ptr_q == $past(ram_ptr_q) + 6'h01)
    else $error("packet address moved the register pointer");
  a_header_restart: assert property ($rose(ce_s) |=> (phase_q == PH_HEADER && cnt_q == 4'h0)
    [*2])
    else $error("deselect did not restart header");
  a_soft_defaults: assert property (soft_reset |=> float_q && drive_q == DRIVE_RST)
    else $error("soft reset did not restore miso controls");
  a_msb_out: assert property (fall && phase_q == PH_DATA && rw_q && !load_q |=>
    miso_out == $past(tx_sh_q[15]))
    else $error("miso bit not the word msb");
  a_read_loads: assert property (rd_req |-> ##2 tx_sh_q == $past(
    src_q == SRC_REGS ? regs_rdata : src_q == SRC_RX_RAM ? rx_rdata : stream_buf_q))
    else $error("read word not loaded");
  a_pack_word: assert property (word_ready && !stream_q |-> rx_req.we &&
    rx_req.wdata[15:12] == pwdata[3:0])
    else $error("fourth symbol not in the top nibble");

  c_recursive_wrap: cover property (word_done && rw_q && ptr_q == REG_LAST);
  c_soft_reset: cover property (soft_reset);
  c_aborted_frame: cover property ($rose(ce_s) && phase_q == PH_DATA);
  c_stream_read: cover property (load_q && src_q == SRC_STREAM);
endmodule : spi_slave_port

// [bench/spi_host_model.sv]
// host-side serial master model for the transceiver control port
// assumes the port oversamples these lines with its own core clock
module spi_host_model (
  output logic serial_clock_in, // serial clock, idles low
  output logic chip_en_n, // frame select, active low
  output logic mosi_in, // host to device data
  input wire logic miso_out, // device data
  input wire logic miso_oe // device drive enable
);
  timeunit 1ns;
  timeprecision 100ps;

  logic bit_in;

  // idle levels at time zero
  initial begin
    serial_clock_in = 1'b0;
    chip_en_n = 1'b1;
    mosi_in = 1'b0;
    bit_in = 1'b0;
  end

  // one framed transfer of n bits; tx and rx are msb aligned
  task automatic frame(input int n, input logic [135:0] tx, output logic [135:0] rx);
    rx = '0;
    chip_en_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      mosi_in = tx[135-i];
      #62.5 serial_clock_in = 1'b1;
      bit_in = miso_oe ? miso_out : ~bit_in; // released line shows no stale value
      rx[135-i] = bit_in;
      #62.5 serial_clock_in = 1'b0;
    end
    mosi_in = ~mosi_in; // no longer meaningful
    #40 chip_en_n = 1'b1;
    #200;
  endtask : frame
endmodule : spi_host_model

// [bench/transceiver_spi_slave_port_tb_top.sv]
// self-checking bench for the serial slave control port
// assumes the host model drives the serial pins and tasks here speak apb
module transceiver_spi_slave_port_tb_top import spi_port_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk, rst, serial_clock_in, chip_en_n, mosi_in, miso_out, miso_oe;
  logic [1:0] miso_drive;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [127:0] w;
  logic [135:0] rx;
  logic e;
  int fail_count, n_checks, cyc;

  spi_slave_port spi_slave_port_inst (.core_clk(core_clk), .rst(rst),
    .serial_clock_in(serial_clock_in), .chip_en_n(chip_en_n), .mosi_in(mosi_in),
    .miso_out(miso_out), .miso_oe(miso_oe), .miso_drive(miso_drive), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  spi_host_model spi_host_model_inst (.serial_clock_in(serial_clock_in),
    .chip_en_n(chip_en_n), .mosi_in(mosi_in), .miso_out(miso_out), .miso_oe(miso_oe));

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(t < 50), 32'h1, "apb no ready");
  endtask : apb

  // serial write and read of nw words starting at a
  task automatic sw(input logic [5:0] a, input int nw, input logic [127:0] d);
    spi_host_model_inst.frame(8 + 16 * nw, {2'b00, a, d}, rx);
  endtask : sw

  task automatic sr(input logic [5:0] a, input int nw);
    spi_host_model_inst.frame(8 + 16 * nw, {2'b10, a, {8{16'hA55A}}}, rx);
    w = rx[127:0];
  endtask : sr

  task automatic t_reset();
    apb(1'b0, APB_STATUS, 32'h0);
    chk(32'(miso_oe), 32'h0, "oe after reset");
    chk(32'(miso_drive), 32'h0, "drive after reset");
    chk(32'(q[18:16]), 32'h1, "status float/drive");
    apb(1'b1, 8'h10, 32'hFFFF);
    chk(32'(e), 32'h1, "unmapped write err");
    apb(1'b0, 8'h10, 32'h0);
    chk({q[31:1], e}, 32'h1, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_words();
    sw(6'h05, 2, {16'hA5C3, 16'h5A3C, 96'h0});
    sr(6'h05, 2);
    chk(32'(w[127:96]), 32'hA5C35A3C, "words 05/06");
    sw(6'h3E, 3, {16'h1111, 16'h2222, 16'h3333, 80'h0});
    sr(6'h3E, 3);
    chk(32'(w[127:96]), 32'h11112222, "recursive 3E/3F");
    chk(32'(w[95:80]), 32'h3333, "read wrap");
    sr(6'h03, 1);
    chk(32'(w[127:112]), 32'h3333, "write wrap to 03");
    $display("test words done");
  endtask : t_words

  task automatic t_abort();
    spi_host_model_inst.frame(23, {2'b00, 6'h05, 16'hFFFF, 112'h0}, rx);
    spi_host_model_inst.frame(32, {2'b00, 6'h05, 16'h0F0F, 16'hF0F0, 96'h0}, rx);
    sr(6'h05, 2);
    chk(32'(w[127:96]), 32'h0F0F5A3C, "short or partial frame");
    $display("test abort done");
  endtask : t_abort

  task automatic t_miso();
    sw(REG_FLOAT_CTRL, 1, 128'h0);
    chk(32'({miso_oe, miso_out}), 32'h2, "float clear drives low");
    sw(REG_DRIVE_CTRL, 1, {16'h0003, 112'h0});
    chk(32'(miso_drive), 32'h3, "strongest drive");
    sw(REG_SOFT_RESET, 1, {16'hFFFF, 112'h0});
    chk(32'({miso_oe, miso_drive}), 32'h0, "soft reset");
    $display("test miso done");
  endtask : t_miso

  task automatic t_symbols();
    apb(1'b1, APB_CTRL, 32'h2);
    for (int i = 1; i <= 8; i++) begin
      apb(1'b1, APB_SYMBOL, 32'(i));
    end
    sr(REG_RX_RAM, 2);
    chk(32'(w[127:96]), 32'h43218765, "packet symbols");
    apb(1'b1, APB_CTRL, 32'h1);
    for (int i = 9; i <= 12; i++) begin
      apb(1'b1, APB_SYMBOL, 32'(i));
    end
    sr(REG_RX_RAM, 1);
    chk(32'(w[127:112]), 32'hCBA9, "stream symbols");
    apb(1'b1, APB_CTRL, 32'h0);
    $display("test symbols done");
  endtask : t_symbols

  task automatic t_tx();
    sw(REG_TX_RAM, 2, {16'hBEEF, 16'hCAFE, 96'h0});
    apb(1'b1, APB_TXPEEK, 32'h1);
    repeat (2) @(posedge core_clk);
    apb(1'b0, APB_TXPEEK, 32'h0);
    chk(32'(q[15:0]), 32'hCAFE, "tx word 1");
    apb(1'b1, APB_TXPEEK, 32'h0);
    repeat (2) @(posedge core_clk);
    apb(1'b0, APB_TXPEEK, 32'h0);
    chk(32'(q[15:0]), 32'hBEEF, "tx word 0");
    $display("test tx done");
  endtask : t_tx

  // core clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    t_reset();
    t_words();
    t_abort();
    t_miso();
    t_symbols();
    t_tx();
    report_and_stop();
  end
endmodule : transceiver_spi_slave_port_tb_top
